// File: src/mtue_pkg.sv
package mtue_pkg;
  // ----------------------------------------------------------------
  // Clock, rates and derived bit periods
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 125_000_000; // System clock
  localparam int unsigned RATE_75_BPS   = 75;          // Bit rates
  localparam int unsigned RATE_150_BPS  = 150;
  localparam int unsigned RATE_300_BPS  = 300;
  localparam int unsigned RATE_600_BPS  = 600;
  localparam int unsigned RATE_1200_BPS = 1200;
  localparam int unsigned RATE_2400_BPS = 2400;
  localparam int unsigned SYMBOL_RATE   = 600;         // Phase symbols/s
  localparam int unsigned CARRIER_LO_HZ = 1200;        // Calling band
  localparam int unsigned CARRIER_HI_HZ = 2400;        // Answering band
  localparam int          CNT_W         = 21;          // Bit timer width
  localparam int unsigned CYC_75   = CLK_HZ / RATE_75_BPS;
  localparam int unsigned CYC_150  = CLK_HZ / RATE_150_BPS;
  localparam int unsigned CYC_300  = CLK_HZ / RATE_300_BPS;
  localparam int unsigned CYC_600  = CLK_HZ / RATE_600_BPS;
  localparam int unsigned CYC_1200 = CLK_HZ / RATE_1200_BPS;
  localparam int unsigned CYC_2400 = CLK_HZ / RATE_2400_BPS;
  localparam int          SHORT_STOP_SHIFT = 3;        // Cut of 1/8 bit
  // ----------------------------------------------------------------
  // Control bus frame and register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_TX_NORMAL = 8'he3; // Ordinary data
  localparam logic [7:0] ADDR_TX_SHORT  = 8'he4; // One stop less in phase modes, final stop cut by 1/8 in FSK
  localparam logic [4:0] FRAME_LAST_BIT = 5'h0f; // Addr byte + data
  localparam logic [4:0] ADDR_LAST_BIT  = 5'h07;
  // ----------------------------------------------------------------
  // Scrambler and phase constants
  // ----------------------------------------------------------------
  localparam logic [6:0] SCR_ONES_LIMIT = 7'h40; // 64 ones
  localparam int         SCR_TAP_A      = 14;
  localparam int         SCR_TAP_B      = 17;
  localparam logic [1:0] PH_0   = 2'h0;          // Quarter turns
  localparam logic [1:0] PH_90  = 2'h1;
  localparam logic [1:0] PH_180 = 2'h2;
  localparam logic [1:0] PH_270 = 2'h3;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_DATA  = 8'h00;
  localparam logic [1:0] RST_PHASE = 2'h0;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    M_DISABLED, M_V21, M_B103, M_V23_1200, M_V23_75, M_B202_1200,
    M_B202_150, M_DPSK_600, M_DPSK_1200, M_QAM_2400, M_TONES
  } mtue_mode_t;
  typedef enum logic {F_SYNC, F_START_STOP} mtue_fmt_t;
  typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PARITY, S_STOP}
    mtue_state_t;
  typedef struct packed {
    mtue_mode_t mode;       // Transmit mode
    mtue_fmt_t  fmt;        // Synchronous or start-stop
    logic [1:0] data_bits;  // 0..3 means 5..8 data bits
    logic       parity_en;  // Parity bit present
    logic       parity_odd; // Odd parity
    logic       two_stop;   // Two stop bits
    logic       high_band;  // Answering carrier
    logic       scram_en;   // Scrambler on
  } mtue_cfg_t;
  typedef struct packed {
    logic       short_stop; // Written through alternate address
    logic [7:0] data;       // Character
  } mtue_word_t;
endpackage

// File: src/mtue_tx.sv
`timescale 1ns/1ns
module mtue_tx
  import mtue_pkg::*;
#(
  parameter int unsigned P_CYC_75   = CYC_75,   // Bit period at 75 bps
  parameter int unsigned P_CYC_150  = CYC_150,  // Bit period at 150 bps
  parameter int unsigned P_CYC_300  = CYC_300,  // Bit period at 300 bps
  parameter int unsigned P_CYC_600  = CYC_600,  // Bit period at 600 bps
  parameter int unsigned P_CYC_1200 = CYC_1200, // Bit period at 1200 bps
  parameter int unsigned P_CYC_2400 = CYC_2400  // Bit period at 2400 bps
)(
  input  wire logic       sys_clk,        // System clock
  input  wire logic       reset_n,        // Async reset, low
  input  wire logic       serial_clk,     // Control bus clock
  input  wire logic       csn_n,          // Control bus select, low
  input  wire logic       cmd_data,       // Control bus data in
  output logic            reply_data,     // Control bus data out
  output logic            reply_data_oe,  // Reply drive enable
  input  wire logic       powersave,      // Standby request pin
  input  wire mtue_cfg_t  cfg,            // Transmit configuration
  output logic            buffer_free,    // Data register empty
  output logic            underflow,      // Transfer found no data
  output logic            tx_bit,         // Bit after scrambler
  output logic            bit_strobe,     // New tx_bit pulse
  output logic            fsk_active,     // FSK modulator in use
  output logic            fsk_freq_sel,   // Tone choice, 1 = mark
  output logic            psk_active,     // Phase modulator in use
  output logic            carrier_high,   // 2400 Hz carrier
  output logic            symbol_strobe,  // New phase symbol pulse
  output logic [1:0]      phase_quadrant, // Absolute quadrant
  output logic [1:0]      qam_point       // Point inside quadrant
);
  // ----------------------------------------------------------------
  // Control bus receiver on the link clock
  // ----------------------------------------------------------------
  logic [4:0]  lk_cnt;    // Bit position in frame
  logic [14:0] lk_shift;  // Bits shifted in so far
  logic        lk_toggle; // Flips per accepted write
  mtue_word_t  lk_word;   // Held until next write

  assign reply_data    = 1'b0;
  assign reply_data_oe = 1'b0;

  // Frame position, cleared while select is high
  always_ff @(posedge serial_clk or posedge csn_n)
  begin
    if (csn_n)
      lk_cnt <= 5'h00;
    else if (lk_cnt != FRAME_LAST_BIT)
      lk_cnt <= lk_cnt + 5'h01;
    else
      lk_cnt <= 5'h00;
  end

  // Shift register and write capture
  always_ff @(posedge serial_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lk_shift  <= 15'h0000;
      lk_toggle <= 1'b0;
      lk_word   <= '0;
    end
    else if (!csn_n)
    begin
      lk_shift <= {lk_shift[13:0], cmd_data};
      if (lk_cnt == FRAME_LAST_BIT &&
          (lk_shift[14:7] == ADDR_TX_NORMAL ||
           lk_shift[14:7] == ADDR_TX_SHORT))
      begin
        lk_word.short_stop <= (lk_shift[14:7] == ADDR_TX_SHORT);
        lk_word.data       <= {lk_shift[6:0], cmd_data};
        lk_toggle          <= ~lk_toggle;
      end
    end
  end

  // ----------------------------------------------------------------
  // Crossing into the system clock
  // ----------------------------------------------------------------
  logic [2:0] tg_sync;  // Toggle synchroniser plus edge stage
  logic [1:0] ps_sync;  // Standby synchroniser
  logic       wr_pulse; // One cycle per host write
  logic       standby;  // Synchronised standby

  // Two flops per crossing, third only for the toggle edge
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tg_sync <= 3'h0;
      ps_sync <= 2'h0;
    end
    else
    begin
      tg_sync <= {tg_sync[1:0], lk_toggle};
      ps_sync <= {ps_sync[0], powersave};
    end
  end
  assign wr_pulse = tg_sync[2] ^ tg_sync[1];
  assign standby  = ps_sync[1];

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  logic                 is_fsk;   // FSK family
  logic                 is_psk;   // DPSK or QAM
  logic                 active;   // Serialiser running
  logic                 is_sync;  // Synchronous format
  logic [CNT_W-1:0]     bit_cyc;  // Bit period in cycles
  logic [CNT_W-1:0]     short_cyc;// Shortened stop length

  always_comb
  begin
    is_fsk  = 1'b0;
    is_psk  = 1'b0;
    bit_cyc = CNT_W'(P_CYC_300);
    unique case (cfg.mode)
      M_V21, M_B103: is_fsk = 1'b1;
      M_V23_1200, M_B202_1200:
      begin
        is_fsk  = 1'b1;
        bit_cyc = CNT_W'(P_CYC_1200);
      end
      M_V23_75:
      begin
        is_fsk  = 1'b1;
        bit_cyc = CNT_W'(P_CYC_75);
      end
      M_B202_150:
      begin
        is_fsk  = 1'b1;
        bit_cyc = CNT_W'(P_CYC_150);
      end
      M_DPSK_600:
      begin
        is_psk  = 1'b1;
        bit_cyc = CNT_W'(P_CYC_600);
      end
      M_DPSK_1200:
      begin
        is_psk  = 1'b1;
        bit_cyc = CNT_W'(P_CYC_1200);
      end
      M_QAM_2400:
      begin
        is_psk  = 1'b1;
        bit_cyc = CNT_W'(P_CYC_2400);
      end
      default: ;
    endcase
  end
  assign active    = (is_fsk | is_psk) & ~standby;
  assign is_sync   = (cfg.fmt == F_SYNC);
  assign short_cyc = bit_cyc - (bit_cyc >> SHORT_STOP_SHIFT);

  // ----------------------------------------------------------------
  // Data register and buffer
  // ----------------------------------------------------------------
  mtue_word_t  hold;      // Host data register
  logic        full;      // Register holds unsent byte
  mtue_word_t  txbuf;     // Transmit buffer
  logic        fetch;     // Transfer moment
  logic        bit_tick;  // End of current bit
  mtue_state_t state;     // Serialiser state

  // Register load and flag, write wins over transfer
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hold <= '0;
      full <= 1'b0;
    end
    else if (wr_pulse)
    begin
      hold <= lk_word;
      full <= 1'b1;
    end
    else if (fetch)
      full <= 1'b0;
  end
  assign buffer_free = ~full;

  // Underflow is sticky until the next host write
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      underflow <= 1'b0;
    else if (fetch && !full)
      underflow <= 1'b1;
    else if (wr_pulse)
      underflow <= 1'b0;
  end

  // Buffer loads on transfer; kept on underflow for resending in sync format
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      txbuf <= '0;
    else if (fetch && full)
      txbuf <= hold;
  end

  // ----------------------------------------------------------------
  // Serialiser
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] cnt;           // Bit timer
  logic [2:0]       idx;           // Data bit index
  logic [1:0]       stop_left;     // Stop bits still to send
  logic             line;          // Current line bit
  logic [2:0]       last_idx;      // Final data bit index
  logic [1:0]       n_stop;        // Stops for this character
  logic             parity;        // Generated parity
  mtue_state_t      next_state;
  logic [2:0]       next_idx;
  logic [1:0]       next_stop_left;
  logic             next_line;
  logic             next_short;    // Next bit is final stop
  mtue_word_t       src;           // Character about to start

  assign bit_tick = active && (cnt == CNT_W'(1));
  assign last_idx = is_sync ? 3'h7 : {1'b1, cfg.data_bits};
  // parity from the used data bits and parity_odd only
  assign parity = ^(txbuf.data & ~(8'hff << {1'b0, last_idx} << 1)) ^
                  cfg.parity_odd;
  // one stop fewer for short-stop characters in phase modes
  assign n_stop = {1'b0, 1'b1} + {1'b0, cfg.two_stop} -
                  {1'b0, txbuf.short_stop & is_psk};
  assign src    = full ? hold : txbuf;

  // Next bit selection at each bit boundary
  always_comb
  begin
    fetch          = 1'b0;
    next_state     = state;
    next_idx       = idx;
    next_stop_left = stop_left;
    next_line      = line;
    next_short     = 1'b0;
    if (bit_tick)
    begin
      unique case (state)
        S_IDLE:   fetch = 1'b1;
        S_START:
        begin
          next_state = S_DATA;
          next_idx   = 3'h0;
          next_line  = txbuf.data[0];
        end
        S_DATA:
        begin
          if (idx != last_idx)
          begin
            next_idx  = idx + 3'h1;
            next_line = txbuf.data[idx + 3'h1];
          end
          else if (is_sync)
            fetch = 1'b1;
          else if (cfg.parity_en)
          begin
            next_state = S_PARITY;
            next_line  = parity;
          end
          else if (n_stop == 2'h0)
            fetch = 1'b1;
          else
          begin
            next_state     = S_STOP;
            next_line      = 1'b1;
            next_stop_left = n_stop;
            next_short     = (n_stop == 2'h1);
          end
        end
        S_PARITY:
        begin
          if (n_stop == 2'h0)
            fetch = 1'b1;
          else
          begin
            next_state     = S_STOP;
            next_line      = 1'b1;
            next_stop_left = n_stop;
            next_short     = (n_stop == 2'h1);
          end
        end
        S_STOP:
        begin
          if (stop_left != 2'h1)
          begin
            next_stop_left = stop_left - 2'h1;
            next_short     = 1'b1;
          end
          else
            fetch = 1'b1;
        end
        default: fetch = 1'b1;
      endcase
      if (fetch)
      begin
        if (is_sync)
        begin
          next_state = S_DATA;
          next_idx   = 3'h0;
          next_line  = src.data[0];
        end
        else if (full)
        begin
          next_state = S_START;
          next_line  = 1'b0;
        end
        else
        begin
          next_state = S_IDLE;
          next_line  = 1'b1;
        end
      end
    end
  end

  // Serialiser state registers
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state     <= S_IDLE;
      idx       <= 3'h0;
      stop_left <= 2'h0;
      line      <= 1'b1;
    end
    else if (!active)
    begin
      state <= S_IDLE;
      line  <= 1'b1;
    end
    else
    begin
      state     <= next_state;
      idx       <= next_idx;
      stop_left <= next_stop_left;
      line      <= next_line;
    end
  end

  // Bit timer, reloads at each boundary
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      cnt <= CNT_W'(1);
    else if (!active)
      cnt <= CNT_W'(1);
    else if (bit_tick)
    begin
      // FSK final stop cut by 1/8
      if (next_short && is_fsk && next_stop_left == 2'h1 &&
          txbuf.short_stop && !is_sync)
        cnt <= short_cyc;
      else
        cnt <= bit_cyc;
    end
    else
      cnt <= cnt - CNT_W'(1);
  end

  // ----------------------------------------------------------------
  // Scrambler
  // ----------------------------------------------------------------
  logic [16:0] scr_sr;   // Past output bits
  logic [6:0]  ones;     // Consecutive input ones
  logic        scr_in;   // Input after forced inversion
  logic        scr_out;  // Scrambled bit

  assign scr_in  = (ones == SCR_ONES_LIMIT) ? ~next_line : next_line;
  assign scr_out = scr_in ^ scr_sr[SCR_TAP_A-1] ^ scr_sr[SCR_TAP_B-1];

  // Scrambler advances once per bit
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scr_sr     <= 17'h00000;
      ones       <= 7'h00;
      tx_bit     <= 1'b1;
      bit_strobe <= 1'b0;
    end
    else
    begin
      bit_strobe <= bit_tick;
      if (bit_tick && cfg.scram_en)
      begin
        scr_sr <= {scr_sr[15:0], scr_out};
        if (ones == SCR_ONES_LIMIT || !next_line)
          ones <= 7'h00;
        else
          ones <= ones + 7'h01;
        tx_bit <= scr_out;
      end
      else if (bit_tick)
        tx_bit <= next_line;
    end
  end

  // ----------------------------------------------------------------
  // Modulator mapping
  // ----------------------------------------------------------------
  logic [2:0] grp;      // Earlier bits of symbol
  logic [1:0] grp_cnt;  // Bits collected
  logic [1:0] last_bit; // Final bit index of symbol
  logic [1:0] delta;    // Quadrant change

  function automatic logic [1:0] dibit_phase(input logic [1:0] d);
    unique case (d)
      2'b00: dibit_phase = PH_90;
      2'b01: dibit_phase = PH_0;
      2'b11: dibit_phase = PH_270;
      2'b10: dibit_phase = PH_180;
    endcase
  endfunction

  assign last_bit = (cfg.mode == M_QAM_2400)  ? 2'h3 :
                    (cfg.mode == M_DPSK_1200) ? 2'h1 : 2'h0;

  always_comb
  begin
    unique case (last_bit)
      2'h0:    delta = tx_bit ? PH_270 : PH_90;
      2'h1:    delta = dibit_phase({grp[0], tx_bit});
      default: delta = dibit_phase({grp[2], grp[1]});
    endcase
  end

  // Symbol assembly and phase accumulation
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      grp            <= 3'h0;
      grp_cnt        <= 2'h0;
      symbol_strobe  <= 1'b0;
      phase_quadrant <= RST_PHASE;
      qam_point      <= RST_PHASE;
    end
    else
    begin
      symbol_strobe <= 1'b0;
      if (!psk_active)
        grp_cnt <= 2'h0;
      else if (bit_strobe)
      begin
        grp <= {grp[1:0], tx_bit};
        if (grp_cnt == last_bit)
        begin
          grp_cnt        <= 2'h0;
          symbol_strobe  <= 1'b1;
          phase_quadrant <= phase_quadrant + delta;
          // last two bits pick the point
          if (last_bit == 2'h3)
            qam_point <= {grp[0], tx_bit};
        end
        else
          grp_cnt <= grp_cnt + 2'h1;
      end
    end
  end

  // FSK tone and family flags
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fsk_active   <= 1'b0;
      psk_active   <= 1'b0;
      carrier_high <= 1'b0;
      fsk_freq_sel <= 1'b1;
    end
    else
    begin
      fsk_active   <= is_fsk & ~standby;
      psk_active   <= is_psk & ~standby;
      carrier_high <= cfg.high_band;
      if (bit_strobe && fsk_active)
        fsk_freq_sel <= tx_bit;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_free_on_load: assert property (fetch && full && !wr_pulse |=> buffer_free)
    else $error("free flag not set on transfer");
  a_free_clear: assert property (wr_pulse |=> !buffer_free)
    else $error("free flag not cleared by write");
  a_underflow_set: assert property (fetch && !full |=> underflow)
    else $error("underflow not flagged");
  a_sync_resend: assert property (fetch && !full && is_sync |=> txbuf == $past(txbuf))
    else $error("buffer changed on sync underflow");
  a_idle_mark: assert property (state == S_IDLE |-> line)
    else $error("line not at stop level while idle");
  a_start_low: assert property (state == S_START |-> !line && !is_sync)
    else $error("start bit wrong");
  a_stop_high: assert property (state == S_STOP |-> line)
    else $error("stop bit not high");
  a_sync_frame: assert property (active && is_sync && $past(active) |-> state == S_DATA || state == S_IDLE)
    else $error("framing bit in sync mode");
  a_psk_drop: assert property (txbuf.short_stop && is_psk && !cfg.two_stop |-> n_stop == 2'h0)
    else $error("stop not dropped");
  a_scr_invert: assert property (bit_tick && cfg.scram_en && ones == SCR_ONES_LIMIT |=> ones == 7'h00)
    else $error("ones run not reset after inversion");
  a_dpsk_step: assert property (bit_strobe && psk_active && cfg.mode == M_DPSK_600 |=> 2'(phase_quadrant - $past(phase_quadrant)) == ($past(tx_bit) ? PH_270 : PH_90))
    else $error("dpsk phase step wrong");
  a_standby_halt: assert property (standby |=> state == S_IDLE ##1 !bit_strobe)
    else $error("serialiser ran in standby");

  c_sync_word: cover property (is_sync && fetch && full);
  c_async_char: cover property (state == S_STOP ##1 state == S_START);
  c_underflow: cover property (!is_sync && fetch && !full);
endmodule

// File: tb/mtue_host.sv
`timescale 1ns/1ns
module mtue_host (
  output logic serial_clk, // Bus clock, still between frames
  output logic csn_n,      // Select, low in frame
  output logic cmd_data    // Data, MSB first
);
  initial
  begin
    serial_clk = 1'b0;
    csn_n = 1'b1;
    cmd_data = 1'b0;
  end
  task automatic send(input logic [7:0] addr, input logic [7:0] data);
    logic [15:0] frame;
    frame = {addr, data};
    csn_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      cmd_data = frame[i];
      #16 serial_clk = 1'b1;
      #16 serial_clk = 1'b0;
    end
    #16 csn_n = 1'b1;
    // Released line shows no stale bit
    cmd_data = ~frame[0];
  endtask
endmodule

// File: tb/test_modem_tx_usart_encoder.sv
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_modem_tx_usart_encoder
  import mtue_pkg::*;
;
  logic        sys_clk, reset_n, powersave; // Clock, reset, standby
  mtue_cfg_t   cfg;                          // Transmit setup
  logic        serial_clk, csn_n, cmd_data;  // Bus pins
  logic        buffer_free, underflow;       // Status flags
  logic        tx_bit, bit_strobe;           // Serial stream
  logic        fsk_active, psk_active;       // Modulator choice
  logic        fsk_freq_sel, carrier_high;   // Tone and band choice
  logic [15:0] cap;                          // Captured bits
  int          checks, miscompares;          // Counters

  mtue_host host (.serial_clk(serial_clk), .csn_n(csn_n),
    .cmd_data(cmd_data));
  mtue_tx #(.P_CYC_75(32), .P_CYC_150(32), .P_CYC_300(32),
    .P_CYC_600(32), .P_CYC_1200(32), .P_CYC_2400(32)) dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .serial_clk(serial_clk),
    .csn_n(csn_n), .cmd_data(cmd_data), .reply_data(),
    .reply_data_oe(), .powersave(powersave), .cfg(cfg),
    .buffer_free(buffer_free), .underflow(underflow), .tx_bit(tx_bit),
    .bit_strobe(bit_strobe), .fsk_active(fsk_active),
    .fsk_freq_sel(fsk_freq_sel), .psk_active(psk_active),
    .carrier_high(carrier_high),
    .symbol_strobe(), .phase_quadrant(), .qam_point());

  // Collect n bits, first one equal to lead
  task automatic grab(input int n, input logic lead);
    int i;
    int t;
    i = 0;
    t = 0;
    cap = '0;
    while (i < n && t < 4000)
    begin
      @(posedge sys_clk);
      t++;
      if (bit_strobe === 1'b1 && (i > 0 || tx_bit === lead))
      begin
        cap[i] = tx_bit;
        i++;
      end
    end
  endtask
  // Bounded wait for an empty data register
  task automatic wait_free();
    int t;
    t = 0;
    while (buffer_free !== 1'b1 && t < 400)
    begin
      @(posedge sys_clk);
      t++;
    end
  endtask
  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Watchdog against a hung handshake
  initial
  begin
    #100_000;
    miscompares++;
    conclude();
  end
  initial
  begin
    reset_n = 1'b0;
    powersave = 1'b0;
    cfg = '0;
    checks = 0;
    miscompares = 0;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    cfg.mode <= M_V21;
    cfg.fmt <= F_SYNC;
    `CHK(buffer_free, 1'b1)
    host.send(ADDR_TX_SHORT, 8'h01);
    grab(16, 1'b1);
    `CHK(cap, 16'h0101)
    `CHK(underflow, 1'b1)
    `CHK(fsk_active, 1'b1)
    @(posedge sys_clk);
    `CHK(fsk_freq_sel, cap[15])
    cfg.fmt <= F_START_STOP;
    cfg.data_bits <= 2'h3;
    cfg.parity_en <= 1'b1;
    cfg.two_stop <= 1'b1;
    repeat (400) @(posedge sys_clk);
    host.send(ADDR_TX_NORMAL, 8'ha5);
    grab(14, 1'b0);
    `CHK(cap, 16'h3d4a)
    `CHK(underflow, 1'b1)
    cfg.mode <= M_DPSK_600;
    cfg.data_bits <= 2'h0;
    cfg.parity_en <= 1'b0;
    cfg.two_stop <= 1'b0;
    cfg.high_band <= 1'b1;
    repeat (400) @(posedge sys_clk);
    `CHK(carrier_high, 1'b1)
    fork
      grab(13, 1'b0);
      begin
        host.send(ADDR_TX_SHORT, 8'h1f);
        repeat (6) @(posedge sys_clk);
        wait_free();
        host.send(ADDR_TX_NORMAL, 8'h0a);
        repeat (6) @(posedge sys_clk);
        `CHK(buffer_free, 1'b0)
      end
    join
    `CHK(cap, 16'h153e)
    `CHK(psk_active, 1'b1)
    powersave <= 1'b1;
    repeat (8) @(posedge sys_clk);
    `CHK(psk_active, 1'b0)
    conclude();
  end
endmodule
